// File: verilog/asd_decoder.v
// Function
// - id 3 selects flush/probe by address bits
// - store flushes, load probes with result
// - flush purges all matching descriptor entries
// - probe one cache, flush both caches
// - id 4 register select, low byte ignored
// - register read one cache, write both
// - non-word register access flagged error
// - ids 5-7 diagnostic descriptor cache access
// - ids 8-B normal instruction/data spaces
// - ids C/D instruction cache tag/data
// - ids E/F data cache tag/data
// - tag subfield and dual tag select
// - ids 10-14 flush line both caches
// - page flush compare criteria
// - segment and region flush compare
// - context flush user lines matching context
// - ids 18-1C flush instruction cache only
// - recognise 3-B and pass-through 20-2F
// - id 2 system status registers
// - reserved ids have no function
// - pass-through physical address from id bits
`timescale 1ns/100ps
`default_nettype none
`include "asd_map.vh"
module asd_decoder (
  input  wire                  ref_clk,
  input  wire                  rst_n,
  input  wire                  acc_valid,
  input  wire                  acc_write,
  input  wire [1:0]            acc_size,
  input  wire [7:0]            alternate_space_id,
  input  wire [31:0]           acc_va,
  input  wire                  acc_is_instr,
  input  wire [`ASD_CTX_W-1:0] ctx_value,
  input  wire [31:12]          line_vtag,
  input  wire                  line_super,
  input  wire [`ASD_CTX_W-1:0] line_ctx,
  output reg                   done_reg,
  output reg                   err_reg,
  output reg                   mmu_hit_reg,
  output reg  [3:0]            target_reg,
  output reg  [3:0]            op_sel_reg,
  output reg  [1:0]            tag_sub_reg,
  output reg                   tag_dual_reg,
  output reg                   tlb_i_en_reg,
  output reg                   tlb_d_en_reg,
  output reg                   tlb_io_en_reg,
  output reg                   tlb_flush_reg,
  output reg                   tlb_probe_reg,
  output reg                   reg_wr_reg,
  output reg                   reg_rd_reg,
  output reg                   icache_en_reg,
  output reg                   dcache_en_reg,
  output reg                   line_flush_reg,
  output reg  [2:0]            flush_type_reg,
  output reg  [31:12]          flush_va_reg,
  output reg  [`ASD_CTX_W-1:0] flush_ctx_reg,
  output reg                   line_hit_reg,
  output reg                   space_super_reg,
  output reg  [35:0]           pa_reg
);
  // ----------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------
  reg  [3:0] tgt_next;
  reg        rec_next;
  reg        err_next;
  reg        pi_next;
  reg        pd_next;
  reg        pio_next;
  reg        fl_next;
  reg        pr_next;
  reg        rw_next;
  reg        rr_next;
  reg        ic_next;
  reg        dc_next;
  reg        lf_next;
  reg        sup_next;
  wire       line_hit_c;
  wire [35:0] pa_c;
  wire [7:0] id;
  assign id = alternate_space_id;

  asd_flush_cmp u_cmp (
    .flush_type (id[2:0]),
    .flush_va   (acc_va[31:12]),
    .cur_ctx    (ctx_value),
    .line_vtag  (line_vtag),
    .line_super (line_super),
    .line_ctx   (line_ctx),
    .line_hit   (line_hit_c)
  );

  asd_pass_map u_pass (
    .alt_id (id),
    .va     (acc_va),
    .pa     (pa_c)
  );

  // decode every id bit into target and strobes
  always @* begin
    tgt_next = `ASD_TGT_NONE;
    rec_next = 1'b0;
    err_next = 1'b0;
    pi_next  = 1'b0;
    pd_next  = 1'b0;
    pio_next = 1'b0;
    fl_next  = 1'b0;
    pr_next  = 1'b0;
    rw_next  = 1'b0;
    rr_next  = 1'b0;
    ic_next  = 1'b0;
    dc_next  = 1'b0;
    lf_next  = 1'b0;
    sup_next = 1'b0;
    case (id)
      `ASD_ID_SYSREG: begin
        tgt_next = `ASD_TGT_SYSREG;
      end
      `ASD_ID_FLUSH_PRB: begin
        tgt_next = `ASD_TGT_FLUSH_PRB;
        rec_next = 1'b1;
        fl_next  = acc_write;
        pr_next  = ~acc_write;
        pi_next  = acc_write | acc_is_instr;
        pd_next  = acc_write | ~acc_is_instr;
      end
      `ASD_ID_MMU_REG: begin
        tgt_next = `ASD_TGT_MMU_REG;
        rec_next = 1'b1;
        err_next = (acc_size != `ASD_SZ_WORD);
        rw_next  = acc_write & (acc_size == `ASD_SZ_WORD);
        rr_next  = ~acc_write & (acc_size == `ASD_SZ_WORD);
        pi_next  = acc_write | acc_is_instr;
        pd_next  = acc_write | ~acc_is_instr;
      end
      `ASD_ID_DIAG_I: begin
        tgt_next = `ASD_TGT_DIAG;
        rec_next = 1'b1;
        pi_next  = 1'b1;
      end
      `ASD_ID_DIAG_D: begin
        tgt_next = `ASD_TGT_DIAG;
        rec_next = 1'b1;
        pd_next  = 1'b1;
      end
      `ASD_ID_DIAG_IO: begin
        tgt_next = `ASD_TGT_DIAG;
        rec_next = 1'b1;
        pio_next = 1'b1;
      end
      `ASD_ID_USER_I, `ASD_ID_SUPV_I: begin
        tgt_next = `ASD_TGT_NORMAL;
        rec_next = 1'b1;
        pi_next  = 1'b1;
        sup_next = id[0];
      end
      `ASD_ID_USER_D, `ASD_ID_SUPV_D: begin
        tgt_next = `ASD_TGT_NORMAL;
        rec_next = 1'b1;
        pd_next  = 1'b1;
        sup_next = id[0];
      end
      `ASD_ID_ITAG: begin
        tgt_next = `ASD_TGT_CTAG;
        ic_next  = 1'b1;
      end
      `ASD_ID_IDATA: begin
        tgt_next = `ASD_TGT_CDATA;
        ic_next  = 1'b1;
      end
      `ASD_ID_DTAG: begin
        tgt_next = `ASD_TGT_CTAG;
        dc_next  = 1'b1;
      end
      `ASD_ID_DDATA: begin
        tgt_next = `ASD_TGT_CDATA;
        dc_next  = 1'b1;
      end
      default: begin
        if (id[7:3] == `ASD_ID_FLUSH_ID && id[2:0] <= `ASD_FL_USER) begin
          tgt_next = `ASD_TGT_LFLUSH;
          lf_next  = acc_write;
          ic_next  = acc_write;
          dc_next  = acc_write;
        end else if (id[7:3] == `ASD_ID_FLUSH_IC && id[2:0] <= `ASD_FL_USER) begin
          tgt_next = `ASD_TGT_LFLUSH;
          lf_next  = acc_write;
          ic_next  = acc_write;
        end else if (id[7:4] == `ASD_ID_PASS_HI) begin
          tgt_next = `ASD_TGT_PASS;
          rec_next = 1'b1;
        end
        // ids 0, 1, 15-17, 1D-1F, 30-FF stay without function
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registered outputs, one result per accepted access
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg        <= 1'b0;
      err_reg         <= 1'b0;
      mmu_hit_reg     <= 1'b0;
      target_reg      <= `ASD_TGT_NONE;
      op_sel_reg      <= 4'h0;
      tag_sub_reg     <= 2'h0;
      tag_dual_reg    <= 1'b0;
      tlb_i_en_reg    <= 1'b0;
      tlb_d_en_reg    <= 1'b0;
      tlb_io_en_reg   <= 1'b0;
      tlb_flush_reg   <= 1'b0;
      tlb_probe_reg   <= 1'b0;
      reg_wr_reg      <= 1'b0;
      reg_rd_reg      <= 1'b0;
      icache_en_reg   <= 1'b0;
      dcache_en_reg   <= 1'b0;
      line_flush_reg  <= 1'b0;
      flush_type_reg  <= 3'h0;
      flush_va_reg    <= 20'h0_0000;
      flush_ctx_reg   <= {`ASD_CTX_W{1'b0}};
      line_hit_reg    <= 1'b0;
      space_super_reg <= 1'b0;
      pa_reg          <= 36'h0_0000_0000;
    end else begin
      done_reg       <= acc_valid;
      err_reg        <= acc_valid & err_next;
      mmu_hit_reg    <= acc_valid & rec_next;
      tlb_i_en_reg   <= acc_valid & pi_next & ~err_next;
      tlb_d_en_reg   <= acc_valid & pd_next & ~err_next;
      tlb_io_en_reg  <= acc_valid & pio_next;
      tlb_flush_reg  <= acc_valid & fl_next;
      tlb_probe_reg  <= acc_valid & pr_next;
      reg_wr_reg     <= acc_valid & rw_next;
      reg_rd_reg     <= acc_valid & rr_next;
      icache_en_reg  <= acc_valid & ic_next;
      dcache_en_reg  <= acc_valid & dc_next;
      line_flush_reg <= acc_valid & lf_next;
      line_hit_reg   <= acc_valid & lf_next & line_hit_c;
      if (acc_valid) begin
        target_reg      <= tgt_next;
        op_sel_reg      <= acc_va[`ASD_SEL_HI:`ASD_SEL_LO];
        tag_sub_reg     <= acc_va[`ASD_SUB_HI:`ASD_SUB_LO];
        tag_dual_reg    <= acc_va[`ASD_DUAL_BIT];
        flush_type_reg  <= id[2:0];
        flush_va_reg    <= acc_va[31:12];
        flush_ctx_reg   <= ctx_value;
        space_super_reg <= sup_next;
        pa_reg          <= pa_c;
      end
    end
  end
endmodule // asd_decoder
`default_nettype wire

// File: include/asd_map.vh
`ifndef ASD_MAP_VH
`define ASD_MAP_VH
// ----------------------------------------------------------------
// alternate space identifier codes
// ----------------------------------------------------------------
`define ASD_ID_RSVD0      8'h00
`define ASD_ID_SYSREG     8'h02
`define ASD_ID_FLUSH_PRB  8'h03
`define ASD_ID_MMU_REG    8'h04
`define ASD_ID_DIAG_I     8'h05
`define ASD_ID_DIAG_D     8'h06
`define ASD_ID_DIAG_IO    8'h07
`define ASD_ID_USER_I     8'h08
`define ASD_ID_SUPV_I     8'h09
`define ASD_ID_USER_D     8'h0A
`define ASD_ID_SUPV_D     8'h0B
`define ASD_ID_ITAG       8'h0C
`define ASD_ID_IDATA      8'h0D
`define ASD_ID_DTAG       8'h0E
`define ASD_ID_DDATA      8'h0F
`define ASD_ID_FLUSH_ID   5'h02
`define ASD_ID_FLUSH_IC   5'h03
`define ASD_ID_PASS_HI    4'h2
// ----------------------------------------------------------------
// flush type codes in id bits 2..0
// ----------------------------------------------------------------
`define ASD_FL_PAGE       3'h0
`define ASD_FL_SEGMENT    3'h1
`define ASD_FL_REGION     3'h2
`define ASD_FL_CONTEXT    3'h3
`define ASD_FL_USER       3'h4
// ----------------------------------------------------------------
// address field positions
// ----------------------------------------------------------------
`define ASD_SEL_HI        11
`define ASD_SEL_LO        8
`define ASD_PAGE_LO       12
`define ASD_SEG_LO        18
`define ASD_REG_LO        24
`define ASD_SUB_HI        3
`define ASD_SUB_LO        2
`define ASD_DUAL_BIT      31
// ----------------------------------------------------------------
// access sizes
// ----------------------------------------------------------------
`define ASD_SZ_BYTE       2'h0
`define ASD_SZ_HALF       2'h1
`define ASD_SZ_WORD       2'h2
`define ASD_SZ_DOUBLE     2'h3
// ----------------------------------------------------------------
// target select codes
// ----------------------------------------------------------------
`define ASD_TGT_NONE      4'h0
`define ASD_TGT_SYSREG    4'h1
`define ASD_TGT_FLUSH_PRB 4'h2
`define ASD_TGT_MMU_REG   4'h3
`define ASD_TGT_DIAG      4'h4
`define ASD_TGT_NORMAL    4'h5
`define ASD_TGT_CTAG      4'h6
`define ASD_TGT_CDATA     4'h7
`define ASD_TGT_LFLUSH    4'h8
`define ASD_TGT_PASS      4'h9
`define ASD_CTX_W         8
`endif

// File: verilog/asd_flush_cmp.v
`timescale 1ns/100ps
`default_nettype none
`include "asd_map.vh"
// ----------------------------------------------------------------
// line flush compare for one cache line tag
// ----------------------------------------------------------------
module asd_flush_cmp (
  input  wire [2:0]            flush_type,
  input  wire [31:12]          flush_va,
  input  wire [`ASD_CTX_W-1:0] cur_ctx,
  input  wire [31:12]          line_vtag,
  input  wire                  line_super,
  input  wire [`ASD_CTX_W-1:0] line_ctx,
  output reg                   line_hit
);
  wire context_match;
  assign context_match = (line_ctx == cur_ctx);
  // compare criteria per flush type
  always @* begin
    case (flush_type)
      `ASD_FL_PAGE:
        line_hit = (line_super | context_match) &
                   (line_vtag[31:`ASD_PAGE_LO] == flush_va[31:`ASD_PAGE_LO]);
      `ASD_FL_SEGMENT:
        line_hit = (line_super | context_match) &
                   (line_vtag[31:`ASD_SEG_LO] == flush_va[31:`ASD_SEG_LO]);
      `ASD_FL_REGION:
        line_hit = (line_super | context_match) &
                   (line_vtag[31:`ASD_REG_LO] == flush_va[31:`ASD_REG_LO]);
      `ASD_FL_CONTEXT:
        line_hit = ~line_super & context_match;
      `ASD_FL_USER:
        line_hit = ~line_super; // user lines, detail left to cache
      default:
        line_hit = 1'b0;
    endcase
  end
endmodule // asd_flush_cmp
`default_nettype wire

// File: verilog/asd_pass_map.v
`timescale 1ns/100ps
`default_nettype none
`include "asd_map.vh"
// ----------------------------------------------------------------
// physical address forming for pass-through spaces
// ----------------------------------------------------------------
module asd_pass_map (
  input  wire [7:0]  alt_id,
  input  wire [31:0] va,
  output wire [35:0] pa
);
  assign pa = {alt_id[3:0], va};
endmodule // asd_pass_map
`default_nettype wire

// File: verification/asd_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// core side: one alternate load or store per call
module asd_core_model (
  input  wire logic        ref_clk,
  output var  logic        acc_valid,
  output var  logic        acc_write,
  output var  logic [1:0]  acc_size,
  output var  logic [7:0]  alternate_space_id,
  output var  logic [31:0] acc_va,
  output var  logic        acc_is_instr
);
  // idle lines start low
  initial {acc_valid, acc_write, acc_size, alternate_space_id, acc_va, acc_is_instr} = '0;

  // single request held one edge, then lines show inverted junk
  task issue(input logic [7:0] id, input logic [31:0] va, input logic wr,
             input logic [1:0] sz, input logic ins);
    @(posedge ref_clk);
    #1 {acc_valid, acc_write, acc_size, alternate_space_id, acc_va, acc_is_instr} =
      {1'b1, wr, sz, id, va, ins};
    @(posedge ref_clk);
    #1 {acc_valid, acc_write, acc_size, alternate_space_id, acc_va, acc_is_instr} =
      {1'b0, ~wr, ~sz, ~id, ~va, ~ins};
  endtask
endmodule // asd_core_model
`default_nettype wire

// File: verification/asd_decoder_chk.sv
`timescale 1ns/100ps
`default_nettype none
// watches decoder ports one cycle after each taken access
module asd_decoder_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [1:0]  acc_size,
  input wire logic [7:0]  alternate_space_id,
  input wire logic [31:0] acc_va,
  input wire logic        acc_is_instr,
  input wire logic        done_reg,
  input wire logic        err_reg,
  input wire logic [3:0]  target_reg,
  input wire logic [3:0]  op_sel_reg,
  input wire logic        tlb_i_en_reg,
  input wire logic        tlb_d_en_reg,
  input wire logic        tlb_flush_reg,
  input wire logic        tlb_probe_reg,
  input wire logic        reg_wr_reg,
  input wire logic        reg_rd_reg,
  input wire logic        icache_en_reg,
  input wire logic        dcache_en_reg,
  input wire logic        line_flush_reg,
  input wire logic [35:0] pa_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // taken access whose id lies in a range
  sequence s_acc(logic [7:0] lo, logic [7:0] hi);
    acc_valid && alternate_space_id >= lo && alternate_space_id <= hi;
  endsequence

  done_pulse_a: assert property (acc_valid ##1 !acc_valid |-> done_reg ##1 !done_reg)
    else $error("done not a one cycle answer");
  flush_sel_a: assert property (s_acc(8'h03, 8'h03) |=>
    target_reg == 4'h2 && op_sel_reg == $past(acc_va[11:8]))
    else $error("flush/probe select wrong");
  tlb_flush_a: assert property (s_acc(8'h03, 8'h03) ##0 acc_write |=>
    tlb_flush_reg && !tlb_probe_reg && tlb_i_en_reg && tlb_d_en_reg)
    else $error("flush not sent to both caches");
  tlb_probe_a: assert property (s_acc(8'h03, 8'h03) ##0 !acc_write |=>
    tlb_probe_reg && !tlb_flush_reg && tlb_i_en_reg == $past(acc_is_instr)
    && tlb_d_en_reg != $past(acc_is_instr))
    else $error("probe not sent to one cache");
  reg_size_a: assert property (s_acc(8'h04, 8'h04) ##0 acc_size != 2'h2 |=>
    err_reg && !reg_rd_reg && !reg_wr_reg)
    else $error("bad size register access not flagged");
  reg_write_a: assert property (s_acc(8'h04, 8'h04) ##0 acc_write && acc_size == 2'h2 |=>
    reg_wr_reg && tlb_i_en_reg && tlb_d_en_reg && op_sel_reg == $past(acc_va[11:8]))
    else $error("register write not to both");
  both_flush_a: assert property (s_acc(8'h10, 8'h14) ##0 acc_write |=>
    line_flush_reg && icache_en_reg && dcache_en_reg)
    else $error("combined line flush wrong");
  icache_flush_a: assert property (s_acc(8'h18, 8'h1C) ##0 acc_write |=>
    line_flush_reg && icache_en_reg && !dcache_en_reg)
    else $error("instruction line flush wrong");
  pass_addr_a: assert property (s_acc(8'h20, 8'h2F) |=>
    pa_reg == {$past(alternate_space_id[3:0]), $past(acc_va)})
    else $error("pass-through address wrong");
  high_rsvd_a: assert property (s_acc(8'h80, 8'hFF) |=>
    target_reg == 4'h0 && !line_flush_reg && !tlb_flush_reg && !reg_wr_reg)
    else $error("reserved id had an effect");
endmodule // asd_decoder_chk

bind asd_decoder asd_decoder_chk asd_decoder_chk_i (.ref_clk, .rst_n, .acc_valid, .acc_write,
  .acc_size, .alternate_space_id, .acc_va, .acc_is_instr, .done_reg, .err_reg, .target_reg,
  .op_sel_reg, .tlb_i_en_reg, .tlb_d_en_reg, .tlb_flush_reg, .tlb_probe_reg, .reg_wr_reg,
  .reg_rd_reg, .icache_en_reg, .dcache_en_reg, .line_flush_reg, .pa_reg);
`default_nettype wire

// File: verification/asd_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "asd_map.vh"
module asd_decoder_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic acc_valid, acc_write, acc_is_instr, line_super, done_reg, err_reg, mmu_hit_reg;
  logic tag_dual_reg, tlb_i_en_reg, tlb_d_en_reg, tlb_io_en_reg, tlb_flush_reg, tlb_probe_reg;
  logic reg_wr_reg, reg_rd_reg, icache_en_reg, dcache_en_reg, line_flush_reg, line_hit_reg;
  logic space_super_reg;
  logic [1:0] acc_size, tag_sub_reg;
  logic [7:0] alternate_space_id, ctx_value, line_ctx, flush_ctx_reg;
  logic [31:0] acc_va;
  logic [31:12] line_vtag, flush_va_reg;
  logic [3:0] target_reg, op_sel_reg;
  logic [2:0] flush_type_reg;
  logic [35:0] pa_reg;
  logic [7:0] rsv [12] = '{8'h00, 8'h01, 8'h15, 8'h16, 8'h17, 8'h1D,
                           8'h1E, 8'h1F, 8'h30, 8'h7F, 8'h80, 8'hFF};
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;

  asd_core_model asd_core_model_i (.ref_clk, .acc_valid, .acc_write, .acc_size,
    .alternate_space_id, .acc_va, .acc_is_instr);
  asd_decoder asd_decoder_i (.ref_clk, .rst_n, .acc_valid, .acc_write, .acc_size,
    .alternate_space_id, .acc_va, .acc_is_instr, .ctx_value, .line_vtag, .line_super, .line_ctx,
    .done_reg, .err_reg, .mmu_hit_reg, .target_reg, .op_sel_reg, .tag_sub_reg, .tag_dual_reg,
    .tlb_i_en_reg, .tlb_d_en_reg, .tlb_io_en_reg, .tlb_flush_reg, .tlb_probe_reg, .reg_wr_reg,
    .reg_rd_reg, .icache_en_reg, .dcache_en_reg, .line_flush_reg, .flush_type_reg, .flush_va_reg,
    .flush_ctx_reg, .line_hit_reg, .space_super_reg, .pa_reg);

  // clock and hang guard
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task go(input logic [7:0] id, input logic [31:0] va, input logic wr, input logic [1:0] sz,
          input logic ins);
    asd_core_model_i.issue(id, va, wr, sz, ins);
    chk(done_reg, 1'b1);
  endtask

  task t_flush_probe;
    go(8'h03, 32'h0000_0A5C, 1'b1, `ASD_SZ_WORD, 1'b0);
    chk({target_reg, op_sel_reg}, {`ASD_TGT_FLUSH_PRB, 4'hA});
    chk({tlb_flush_reg, tlb_probe_reg, tlb_i_en_reg, tlb_d_en_reg}, 4'b1011);
    go(8'h03, 32'h0000_0300, 1'b0, `ASD_SZ_WORD, 1'b1);
    chk({op_sel_reg, tlb_flush_reg, tlb_probe_reg, tlb_i_en_reg, tlb_d_en_reg}, 8'h36);
    go(8'h03, 32'h0000_0300, 1'b0, `ASD_SZ_WORD, 1'b0);
    chk({op_sel_reg, tlb_flush_reg, tlb_probe_reg, tlb_i_en_reg, tlb_d_en_reg}, 8'h35);
  endtask

  task t_mmu_reg;
    go(8'h04, 32'h0000_05FF, 1'b1, `ASD_SZ_WORD, 1'b0);
    chk({target_reg, op_sel_reg, reg_wr_reg, reg_rd_reg, tlb_i_en_reg, tlb_d_en_reg, err_reg},
        {`ASD_TGT_MMU_REG, 4'h5, 5'b10110});
    go(8'h04, 32'h0000_0700, 1'b0, `ASD_SZ_WORD, 1'b1);
    chk({op_sel_reg, reg_wr_reg, reg_rd_reg, tlb_i_en_reg, tlb_d_en_reg}, {4'h7, 4'b0110});
    for (int s = 0; s < 4; s++) begin
      if (s != 2) begin
        go(8'h04, 32'h0000_0100, s[0], s[1:0], 1'b0);
        chk({err_reg, reg_wr_reg, reg_rd_reg, tlb_i_en_reg, tlb_d_en_reg}, 5'b10000);
      end
    end
  endtask

  task t_spaces;
    logic [3:0] e;
    for (int i = 2; i < 16; i++) begin
      if (i != 3 && i != 4) begin
        e = (i == 2) ? `ASD_TGT_SYSREG : (i < 8) ? `ASD_TGT_DIAG : (i < 12) ? `ASD_TGT_NORMAL
          : i[0] ? `ASD_TGT_CDATA : `ASD_TGT_CTAG;
        go(i[7:0], 32'h8000_000C, 1'b0, `ASD_SZ_WORD, 1'b0);
        chk(target_reg, e);
        chk({tlb_i_en_reg, tlb_d_en_reg, tlb_io_en_reg},
            {i inside {5, 8, 9}, i inside {6, 10, 11}, i == 7});
        chk(icache_en_reg, i == 12 || i == 13);
        chk(dcache_en_reg, i == 14 || i == 15);
        chk({space_super_reg, mmu_hit_reg}, {i == 9 || i == 11, i > 4 && i < 12});
        chk({tag_dual_reg, tag_sub_reg}, 3'b111);
      end
    end
  endtask

  // one line tag against a flush type, combined then instruction-only
  task lf(input logic [2:0] ft, input logic [31:12] vt, input logic s, input logic [7:0] c,
          input logic e);
    line_vtag = vt;
    line_super = s;
    line_ctx = c;
    go({5'h02, ft}, 32'h1234_5678, 1'b1, `ASD_SZ_WORD, 1'b0);
    chk({line_flush_reg, icache_en_reg, dcache_en_reg, line_hit_reg}, {3'b111, e});
    chk({flush_type_reg, flush_va_reg, flush_ctx_reg}, {ft, 20'h1_2345, 8'h05});
    go({5'h03, ft}, 32'h1234_5678, 1'b1, `ASD_SZ_WORD, 1'b0);
    chk({line_flush_reg, icache_en_reg, dcache_en_reg, line_hit_reg}, {3'b110, e});
  endtask

  task t_line_flush;
    lf(3'h0, 20'h1_2345, 1'b0, 8'h05, 1'b1);
    lf(3'h0, 20'h1_2344, 1'b1, 8'h05, 1'b0);
    lf(3'h0, 20'h1_2345, 1'b0, 8'h06, 1'b0);
    lf(3'h0, 20'h1_2345, 1'b1, 8'h06, 1'b1);
    lf(3'h1, 20'h1_237F, 1'b1, 8'h06, 1'b1);
    lf(3'h1, 20'h1_2305, 1'b1, 8'h05, 1'b0);
    lf(3'h2, 20'h1_2FFF, 1'b0, 8'h05, 1'b1);
    lf(3'h2, 20'h1_3345, 1'b0, 8'h05, 1'b0);
    lf(3'h3, 20'hA_BCDE, 1'b0, 8'h05, 1'b1);
    lf(3'h3, 20'h1_2345, 1'b1, 8'h05, 1'b0);
    lf(3'h3, 20'h1_2345, 1'b0, 8'h06, 1'b0);
    lf(3'h4, 20'h1_2345, 1'b0, 8'h06, 1'b1);
    lf(3'h4, 20'h1_2345, 1'b1, 8'h05, 1'b0);
  endtask

  task t_pass_rsvd;
    go(8'h20, 32'hDEAD_BEEF, 1'b0, `ASD_SZ_WORD, 1'b0);
    chk({target_reg, mmu_hit_reg, pa_reg}, {`ASD_TGT_PASS, 1'b1, 4'h0, 32'hDEAD_BEEF});
    go(8'h2F, 32'h0123_4567, 1'b1, `ASD_SZ_WORD, 1'b0);
    chk(pa_reg, {4'hF, 32'h0123_4567});
    go(8'h10, 32'h1234_5678, 1'b0, `ASD_SZ_WORD, 1'b0);
    chk({line_flush_reg, icache_en_reg, dcache_en_reg}, 3'b000);
    foreach (rsv[k]) begin
      go(rsv[k], 32'h0000_0300, 1'b1, `ASD_SZ_WORD, 1'b0);
      chk({target_reg, line_flush_reg, tlb_flush_reg, reg_wr_reg, tlb_i_en_reg, tlb_d_en_reg,
           mmu_hit_reg}, 10'h000);
    end
  endtask

  // reset in mid-run clears pulses and held fields at once
  task t_reset;
    go(8'h2F, 32'hFFFF_FFFF, 1'b1, `ASD_SZ_WORD, 1'b1);
    rst_n = 1'b0;
    #1 chk({done_reg, mmu_hit_reg, target_reg, pa_reg}, 42'h000_0000_0000);
    @(posedge ref_clk);
    #1 rst_n = 1'b1;
  endtask

  task tally_and_finish;
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // reset, then every scenario in turn
  initial begin
    {line_super, line_vtag, line_ctx} = '0;
    ctx_value = 8'h05;
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_flush_probe();
    t_mmu_reg();
    t_spaces();
    t_line_flush();
    t_reset();
    t_pass_rsvd();
    tally_and_finish();
  end
endmodule // asd_decoder_test
`default_nettype wire
